// ===== src/aret_top.sv
// at-retirement tagging: per-slot tag state, four mechanisms, counters
// assumes all inputs come from core logic on clk; one event per port per cycle
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - a retired metric counts a tagged uop once, however often it hit the event
// - each retiring uop is either cancelled-path or committed-path, never both
// - four mechanisms: front-end, execution, replay, untagged retired counts
// - each mechanism keeps its own tag; detectors never see another's tag
// - replay tagging marks replayed uops and branch mispredictions
// - io, uncacheable, locked, return and far transfer uops are never tagged
// - front-end count covers decode-kind tags and trace-cache tags
// - trace-cache precise selector is not needed for tagging to work
// - upstream selector gives event and tag value; downstream counts tags
// - downstream adds exactly one when any selected tag bit is set
// - tag enable and tag value have no effect in the downstream selector
// - four tag bits count four execution events at once
// - several tag value or mask bits count combinations of events
// - an assist first drains every uop from the machine
// - uops whose conditions are unmet are reissued through replay
module aret_top
	import aret_pkg::*;
(
	input  wire logic                 clk,          // core clock, 250 MHz
	input  wire logic                 rstn,         // async reset, active low
	input  wire logic [ARET_AW-1:0]   reg_addr,     // register byte address
	input  wire logic [ARET_DW-1:0]   reg_wdata,    // register write data
	input  wire logic                 reg_wr,       // write strobe
	input  wire logic                 reg_rd,       // read strobe
	output logic      [ARET_DW-1:0]   reg_rdata,    // read data, cycle after rd
	input  wire logic                 alloc_vld,    // uop enters a slot
	input  wire logic [ARET_ID_W-1:0] alloc_id,     // slot index
	input  wire logic                 alloc_notag,  // io/uc/locked/ret/far uop
	input  wire logic                 alloc_eoi,    // last uop of instruction
	input  wire logic                 fe_evt_vld,   // front-end event seen
	input  wire logic [ARET_ID_W-1:0] fe_evt_id,    // slot of front-end event
	input  wire logic [3:0]           fe_evt_kind,  // decode kinds hit
	input  wire logic                 fe_tc_evt,    // trace-cache event
	input  wire logic                 ex_evt_vld,   // execution event seen
	input  wire logic [ARET_ID_W-1:0] ex_evt_id,    // slot of execution event
	input  wire logic [3:0]           ex_evt_kind,  // execution event kinds
	input  wire logic                 rp_evt_vld,   // conditions unmet, replay
	input  wire logic [ARET_ID_W-1:0] rp_evt_id,    // slot to replay
	input  wire logic                 mp_evt_vld,   // branch mispredicted
	input  wire logic [ARET_ID_W-1:0] mp_evt_id,    // slot of the branch
	input  wire logic                 ret_vld,      // slot retires or cancels
	input  wire logic [ARET_ID_W-1:0] ret_id,       // retiring slot
	input  wire logic                 ret_bogus,    // 1: cancelled path
	input  wire logic                 assist_req,   // microcode assist wanted
	output logic                      alloc_stall,  // hold new uops
	output logic                      assist_go,    // pulse: machine empty
	output logic                      reissue_vld,  // pulse: replay reissue
	output logic      [ARET_ID_W-1:0] reissue_id    // slot reissued
);

	// software-visible configuration
	logic [31:0] fe_ctrl_r, down_sel_r, rp_ctrl_r, untag_ctrl_r, tc_sel_r;
	logic [31:0] up_sel_r [ARET_NUP];
	logic [31:0] cnt_fe_r, cnt_ex_r, cnt_rp_r, cnt_instr_r, cnt_uop_r;

	// per-slot state; each mechanism has its own tag field
	logic                 live_r  [ARET_DEPTH];
	logic                 notag_r [ARET_DEPTH];
	logic                 eoi_r   [ARET_DEPTH];
	logic                 fe_tag_r[ARET_DEPTH];
	logic [ARET_NTAG-1:0] ex_tag_r[ARET_DEPTH];
	logic                 rp_tag_r[ARET_DEPTH];
	logic [ARET_ID_W:0]   inflight_r;
	aret_assist_t         ast_r;

	// path gate: the bogus bit picks exactly one of the two selects
	function automatic logic path_ok(input logic [31:0] ctl, input logic bogus);
		path_ok = bogus ? ctl[ARET_CANCEL_BIT] : ctl[ARET_COMMIT_BIT];
	endfunction : path_ok

	// execution tag bits applied by the four upstream selectors
	function automatic logic [ARET_NTAG-1:0] up_tags(input logic [3:0] kind);
		logic [ARET_NTAG-1:0] t;
		t = '0;
		for (int i = 0; i < ARET_NUP; i++) begin
			if (up_sel_r[i][ARET_UP_TEN_BIT] &&
			    |(up_sel_r[i][ARET_UP_EV_LSB +: 4] & kind))
				t = t | up_sel_r[i][ARET_UP_TVAL_LSB +: ARET_NTAG];
		end
		up_tags = t;
	endfunction : up_tags

	// tags arriving this cycle, merged so a hit in the retire cycle is kept
	logic                 fe_hit, rp_hit;
	logic [ARET_NTAG-1:0] ex_hit;
	logic                 ret_fe, ret_rp, ret_ok;
	logic [ARET_NTAG-1:0] ret_ex, dn_mask;
	always_comb begin
		fe_hit = fe_evt_vld &&
		         (|(fe_evt_kind & fe_ctrl_r[ARET_FE_KIND_LSB +: 4]) || fe_tc_evt);
		ex_hit = ex_evt_vld ? up_tags(ex_evt_kind) : '0;
		rp_hit = rp_ctrl_r[ARET_RP_TAG_BIT];
		ret_ok = ret_vld && live_r[ret_id] && !notag_r[ret_id];
		ret_fe = ret_ok && (fe_tag_r[ret_id] || (fe_hit && fe_evt_id == ret_id));
		ret_ex = ret_ok ? (ex_tag_r[ret_id] | ((ex_evt_id == ret_id) ? ex_hit : '0))
		                : '0;
		ret_rp = ret_ok && (rp_tag_r[ret_id] || (rp_hit &&
		         ((rp_evt_vld && rp_evt_id == ret_id) ||
		          (mp_evt_vld && mp_evt_id == ret_id))));
		// downstream mask only; its tag enable and tag value are ignored
		dn_mask = ret_bogus ? down_sel_r[ARET_DN_CAN_LSB +: ARET_NTAG]
		                    : down_sel_r[ARET_DN_COM_LSB +: ARET_NTAG];
	end

	// slot state: set on events, cleared when the slot retires
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < ARET_DEPTH; i++) begin
				live_r[i]   <= 1'b0;
				notag_r[i]  <= 1'b0;
				eoi_r[i]    <= 1'b0;
				fe_tag_r[i] <= 1'b0;
				ex_tag_r[i] <= '0;
				rp_tag_r[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < ARET_DEPTH; i++) begin
				if (alloc_vld && alloc_id == i[ARET_ID_W-1:0]) begin
					live_r[i]   <= 1'b1;
					notag_r[i]  <= alloc_notag;
					eoi_r[i]    <= alloc_eoi;
					fe_tag_r[i] <= 1'b0;
					ex_tag_r[i] <= '0;
					rp_tag_r[i] <= 1'b0;
				end else if (ret_vld && ret_id == i[ARET_ID_W-1:0]) begin
					live_r[i]   <= 1'b0;
					fe_tag_r[i] <= 1'b0;
					ex_tag_r[i] <= '0;
					rp_tag_r[i] <= 1'b0;
				end else if (live_r[i] && !notag_r[i]) begin
					// each tag bit is sticky, so repeat hits change nothing
					if (fe_hit && fe_evt_id == i[ARET_ID_W-1:0])
						fe_tag_r[i] <= 1'b1;
					if (ex_evt_vld && ex_evt_id == i[ARET_ID_W-1:0])
						ex_tag_r[i] <= ex_tag_r[i] | ex_hit;
					if (rp_hit && ((rp_evt_vld && rp_evt_id == i[ARET_ID_W-1:0]) ||
					               (mp_evt_vld && mp_evt_id == i[ARET_ID_W-1:0])))
						rp_tag_r[i] <= 1'b1;
				end
			end
		end
	end

	// in-flight count for the assist drain
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			inflight_r <= '0;
		else if (alloc_vld && !(ret_vld && live_r[ret_id]))
			inflight_r <= inflight_r + 1'b1;
		else if (!alloc_vld && ret_vld && live_r[ret_id])
			inflight_r <= inflight_r - 1'b1;
	end

	// assist: stop new uops, wait for empty, then hand over for one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ast_r <= ARET_RUN;
		else begin
			case (ast_r)
				ARET_RUN:    if (assist_req) ast_r <= ARET_DRAIN;
				ARET_DRAIN:  if (inflight_r == '0) ast_r <= ARET_ASSIST;
				ARET_ASSIST: ast_r <= ARET_RUN;
				default:     ast_r <= ARET_RUN;
			endcase
		end
	end
	assign alloc_stall = (ast_r != ARET_RUN);
	assign assist_go   = (ast_r == ARET_ASSIST);

	// replay reissue, one cycle after the unmet-condition report
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reissue_vld <= 1'b0;
			reissue_id  <= '0;
		end else begin
			reissue_vld <= rp_evt_vld;
			reissue_id  <= rp_evt_id;
		end
	end

	// register writes; a counter write loads the counter and wins over an increment
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fe_ctrl_r    <= ARET_CFG_RST;
			down_sel_r   <= ARET_CFG_RST;
			rp_ctrl_r    <= ARET_CFG_RST;
			untag_ctrl_r <= ARET_CFG_RST;
			tc_sel_r     <= ARET_CFG_RST;
			for (int i = 0; i < ARET_NUP; i++)
				up_sel_r[i] <= ARET_CFG_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				ARET_FE_CTRL:       fe_ctrl_r    <= reg_wdata;
				ARET_DOWN_SEL:      down_sel_r   <= reg_wdata;
				ARET_RP_CTRL:       rp_ctrl_r    <= reg_wdata;
				ARET_UNTAG_CTRL:    untag_ctrl_r <= reg_wdata;
				ARET_TC_SEL:        tc_sel_r     <= reg_wdata;
				ARET_UP_BASE:       up_sel_r[0]  <= reg_wdata;
				ARET_UP_BASE + 8'h04: up_sel_r[1] <= reg_wdata;
				ARET_UP_BASE + 8'h08: up_sel_r[2] <= reg_wdata;
				ARET_UP_BASE + 8'h0c: up_sel_r[3] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// counters: each mechanism reads only its own tag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_fe_r    <= ARET_CNT_RST;
			cnt_ex_r    <= ARET_CNT_RST;
			cnt_rp_r    <= ARET_CNT_RST;
			cnt_instr_r <= ARET_CNT_RST;
			cnt_uop_r   <= ARET_CNT_RST;
		end else begin
			if (reg_wr && reg_addr == ARET_CNT_FE)
				cnt_fe_r <= reg_wdata;
			else if (ret_fe && path_ok(fe_ctrl_r, ret_bogus))
				cnt_fe_r <= cnt_fe_r + 32'h1;
			if (reg_wr && reg_addr == ARET_CNT_EX)
				cnt_ex_r <= reg_wdata;
			else if (|(ret_ex & dn_mask))
				cnt_ex_r <= cnt_ex_r + 32'h1;
			if (reg_wr && reg_addr == ARET_CNT_RP)
				cnt_rp_r <= reg_wdata;
			else if (ret_rp && path_ok(rp_ctrl_r, ret_bogus))
				cnt_rp_r <= cnt_rp_r + 32'h1;
			if (reg_wr && reg_addr == ARET_CNT_INSTR)
				cnt_instr_r <= reg_wdata;
			else if (ret_vld && live_r[ret_id] && eoi_r[ret_id] &&
			         path_ok(untag_ctrl_r, ret_bogus))
				cnt_instr_r <= cnt_instr_r + 32'h1;
			if (reg_wr && reg_addr == ARET_CNT_UOP)
				cnt_uop_r <= reg_wdata;
			else if (ret_vld && live_r[ret_id] && path_ok(untag_ctrl_r, ret_bogus))
				cnt_uop_r <= cnt_uop_r + 32'h1;
		end
	end

	// read data stands only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else begin
			case (reg_addr)
				ARET_FE_CTRL:         reg_rdata <= fe_ctrl_r;
				ARET_DOWN_SEL:        reg_rdata <= down_sel_r;
				ARET_RP_CTRL:         reg_rdata <= rp_ctrl_r;
				ARET_UNTAG_CTRL:      reg_rdata <= untag_ctrl_r;
				ARET_TC_SEL:          reg_rdata <= tc_sel_r;
				ARET_UP_BASE:         reg_rdata <= up_sel_r[0];
				ARET_UP_BASE + 8'h04: reg_rdata <= up_sel_r[1];
				ARET_UP_BASE + 8'h08: reg_rdata <= up_sel_r[2];
				ARET_UP_BASE + 8'h0c: reg_rdata <= up_sel_r[3];
				ARET_CNT_FE:          reg_rdata <= cnt_fe_r;
				ARET_CNT_EX:          reg_rdata <= cnt_ex_r;
				ARET_CNT_RP:          reg_rdata <= cnt_rp_r;
				ARET_CNT_INSTR:       reg_rdata <= cnt_instr_r;
				ARET_CNT_UOP:         reg_rdata <= cnt_uop_r;
				ARET_STATUS:          reg_rdata <= {26'h0, assist_go, inflight_r};
				default:              reg_rdata <= '0;
			endcase
		end
	end

	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_drain;
		assist_req && ast_r == ARET_RUN ##1 alloc_stall;
	endsequence

	a_assist_empty: assert property (assist_go |-> inflight_r == '0)
		else $error("assist started with uops in flight");
	a_drain_stall: assert property (s_drain |-> ##1 alloc_stall)
		else $error("stall dropped before assist");
	// once draining, the stall may only end after the hand-over cycle
	a_stall_hold: assert property (alloc_stall && !assist_go |=> alloc_stall)
		else $error("stall released while draining");
	a_ex_once: assert property (
		!(reg_wr && reg_addr == ARET_CNT_EX) ##1 cnt_ex_r != $past(cnt_ex_r)
		|-> cnt_ex_r == $past(cnt_ex_r) + 32'h1)
		else $error("execution count moved by other than one");
	a_ex_cause: assert property (
		!(reg_wr && reg_addr == ARET_CNT_EX) && |(ret_ex & dn_mask)
		|=> cnt_ex_r == $past(cnt_ex_r) + 32'h1)
		else $error("selected tag did not count");
	a_notag_clear: assert property (
		ret_vld && notag_r[ret_id] && live_r[ret_id]
		|-> !ret_fe && ret_ex == '0 && !ret_rp)
		else $error("untaggable uop reported tagged");
	a_tag_drop: assert property (
		ret_vld && !alloc_vld |=> fe_tag_r[$past(ret_id)] == 1'b0 &&
		ex_tag_r[$past(ret_id)] == '0 && !rp_tag_r[$past(ret_id)])
		else $error("tag survived retirement");
	a_reissue: assert property (rp_evt_vld |=> reissue_vld && reissue_id == $past(rp_evt_id))
		else $error("replay not reissued");
	a_rd_zero: assert property (reg_rd && reg_addr == 8'hfc |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	a_fe_path: assert property (
		ret_fe && !fe_ctrl_r[ARET_COMMIT_BIT] && !fe_ctrl_r[ARET_CANCEL_BIT] &&
		!(reg_wr && reg_addr == ARET_CNT_FE) |=> $stable(cnt_fe_r))
		else $error("front-end counted with no path selected");

endmodule : aret_top

`default_nettype wire

// ===== src/aret_pkg.sv
// at-retirement tagging: shared register map, field layout and sizes
// assumes a single core clock and a plain one-cycle register port
package aret_pkg;

	// sizes
	localparam int ARET_AW    = 8;   // register address width
	localparam int ARET_DW    = 32;  // register data width
	localparam int ARET_ID_W  = 4;   // in-flight slot index width
	localparam int ARET_DEPTH = 16;  // in-flight slots
	localparam int ARET_NTAG  = 4;   // execution tag bits
	localparam int ARET_NUP   = 4;   // upstream selectors

	// register offsets (byte addresses)
	localparam logic [7:0] ARET_FE_CTRL    = 8'h00;
	localparam logic [7:0] ARET_DOWN_SEL   = 8'h04;
	localparam logic [7:0] ARET_RP_CTRL    = 8'h08;
	localparam logic [7:0] ARET_UNTAG_CTRL = 8'h0c;
	localparam logic [7:0] ARET_TC_SEL     = 8'h10;
	localparam logic [7:0] ARET_UP_BASE    = 8'h20;  // four words 20..2c
	localparam logic [7:0] ARET_CNT_FE     = 8'h40;
	localparam logic [7:0] ARET_CNT_EX     = 8'h44;
	localparam logic [7:0] ARET_CNT_RP     = 8'h48;
	localparam logic [7:0] ARET_CNT_INSTR  = 8'h4c;
	localparam logic [7:0] ARET_CNT_UOP    = 8'h50;
	localparam logic [7:0] ARET_STATUS     = 8'h54;

	// field positions
	localparam int ARET_COMMIT_BIT  = 0;   // count committed-path work
	localparam int ARET_CANCEL_BIT  = 1;   // count cancelled-path work
	localparam int ARET_RP_TAG_BIT  = 2;   // replay tagging enable
	localparam int ARET_FE_KIND_LSB = 4;   // decode-event kinds, 4 bits
	localparam int ARET_UP_EV_LSB   = 0;   // upstream event match, 4 bits
	localparam int ARET_UP_TEN_BIT  = 4;   // upstream tag enable
	localparam int ARET_UP_TVAL_LSB = 5;   // upstream tag value, bits 5..8
	localparam int ARET_DN_COM_LSB  = 9;   // downstream committed tag mask
	localparam int ARET_DN_CAN_LSB  = 13;  // downstream cancelled tag mask

	// reset values
	localparam logic [31:0] ARET_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] ARET_CNT_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		ARET_RUN,
		ARET_DRAIN,
		ARET_ASSIST
	} aret_assist_t;

endpackage : aret_pkg

// ===== dv/aret_top_tb_top.sv
// self-checking bench for the at-retirement tagging block
// assumes the block is driven alone: bench plays register master and core pipeline
`timescale 1ns/1ns
`default_nettype none

module aret_top_tb_top;
	import aret_pkg::*;

	// pulse kinds on the uop side
	localparam logic [2:0] OP_AL = 3'h0, OP_FE = 3'h1, OP_EX = 3'h2, OP_RP = 3'h3;
	localparam logic [2:0] OP_MP = 3'h4, OP_RET = 3'h5, OP_AS = 3'h6;

	logic                 clk, rstn, reg_wr, reg_rd, alloc_vld, alloc_notag, alloc_eoi;
	logic                 fe_evt_vld, fe_tc_evt, ex_evt_vld, rp_evt_vld, mp_evt_vld;
	logic                 ret_vld, ret_bogus, assist_req, alloc_stall, assist_go, reissue_vld;
	logic [ARET_AW-1:0]   reg_addr;
	logic [ARET_DW-1:0]   reg_wdata, reg_rdata;
	logic [ARET_ID_W-1:0] alloc_id, fe_evt_id, ex_evt_id, rp_evt_id, mp_evt_id, ret_id, reissue_id;
	logic [3:0]           fe_evt_kind, ex_evt_kind;
	int                   n_errors, n_compared;

	aret_top aret_top_inst (
		.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alloc_vld(alloc_vld),
		.alloc_id(alloc_id), .alloc_notag(alloc_notag), .alloc_eoi(alloc_eoi),
		.fe_evt_vld(fe_evt_vld), .fe_evt_id(fe_evt_id), .fe_evt_kind(fe_evt_kind),
		.fe_tc_evt(fe_tc_evt), .ex_evt_vld(ex_evt_vld), .ex_evt_id(ex_evt_id),
		.ex_evt_kind(ex_evt_kind), .rp_evt_vld(rp_evt_vld), .rp_evt_id(rp_evt_id),
		.mp_evt_vld(mp_evt_vld), .mp_evt_id(mp_evt_id), .ret_vld(ret_vld), .ret_id(ret_id),
		.ret_bogus(ret_bogus), .assist_req(assist_req), .alloc_stall(alloc_stall),
		.assist_go(assist_go), .reissue_vld(reissue_vld), .reissue_id(reissue_id)
	);

	// 250 MHz core clock
	always #2 clk = ~clk;

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task complete_run;
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// one-cycle register write
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe, so sample there
	task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask : rchk

	// one-cycle pulse on one uop-side port; arg carries kind, notag/eoi or bogus
	task pulse(input logic [2:0] op, input logic [3:0] id, input logic [3:0] arg);
		@(posedge clk);
		case (op)
			OP_AL: begin
				alloc_vld   <= 1'b1;
				alloc_id    <= id;
				alloc_notag <= arg[0];
				alloc_eoi   <= arg[1];
			end
			OP_FE: begin
				fe_evt_vld  <= 1'b1;
				fe_evt_id   <= id;
				fe_evt_kind <= arg;
				fe_tc_evt   <= (arg == 4'h0);
			end
			OP_EX: begin
				ex_evt_vld  <= 1'b1;
				ex_evt_id   <= id;
				ex_evt_kind <= arg;
			end
			OP_RP: begin
				rp_evt_vld <= 1'b1;
				rp_evt_id  <= id;
			end
			OP_MP: begin
				mp_evt_vld <= 1'b1;
				mp_evt_id  <= id;
			end
			OP_RET: begin
				ret_vld   <= 1'b1;
				ret_id    <= id;
				ret_bogus <= arg[0];
			end
			default: assist_req <= 1'b1;
		endcase
		@(posedge clk);
		{alloc_vld, fe_evt_vld, ex_evt_vld, rp_evt_vld, mp_evt_vld, ret_vld, assist_req} <= 7'h00;
		fe_tc_evt <= 1'b0;
	endtask : pulse

	// every register clears to zero; unmapped place reads zero and ignores writes
	task t_reset;
		logic [7:0] a [15];
		a = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2c,
		      8'h40, 8'h44, 8'h48, 8'h4c, 8'h50, 8'h54};
		foreach (a[i])
			rchk("reset value", a[i], 32'h0000_0000);
		wr(8'hfc, 32'hffff_ffff);
		rchk("unmapped read", 8'hfc, 32'h0000_0000);
	endtask : t_reset

	// execution tagging through two upstream selectors and the downstream masks
	task t_exec;
		wr(ARET_UP_BASE, 32'h0000_0031);         // kind 0 -> tag bit 0
		wr(ARET_UP_BASE + 8'h04, 32'h0000_0052); // kind 1 -> tag bit 1
		wr(ARET_DOWN_SEL, 32'h0000_03f0);        // committed tag 0 plus ignored fields
		rchk("down readback", ARET_DOWN_SEL, 32'h0000_03f0);
		pulse(OP_AL, 4'h3, 4'h0);
		pulse(OP_EX, 4'h3, 4'h1);
		pulse(OP_EX, 4'h3, 4'h1);
		pulse(OP_RET, 4'h3, 4'h0);
		rchk("ex once", ARET_CNT_EX, 32'h0000_0001);
		pulse(OP_AL, 4'h3, 4'h0);
		pulse(OP_EX, 4'h3, 4'h1);
		pulse(OP_RET, 4'h3, 4'h1);
		rchk("ex cancelled", ARET_CNT_EX, 32'h0000_0001);
		pulse(OP_AL, 4'h3, 4'h0);
		pulse(OP_RET, 4'h3, 4'h0);
		rchk("ex stale tag", ARET_CNT_EX, 32'h0000_0001);
		pulse(OP_AL, 4'h2, 4'h1);
		pulse(OP_EX, 4'h2, 4'h1);
		pulse(OP_RET, 4'h2, 4'h0);
		rchk("ex notag", ARET_CNT_EX, 32'h0000_0001);
		wr(ARET_DOWN_SEL, 32'h0000_0600);
		pulse(OP_AL, 4'h4, 4'h0);
		pulse(OP_EX, 4'h4, 4'h2);
		pulse(OP_RET, 4'h4, 4'h0);
		rchk("ex tag1", ARET_CNT_EX, 32'h0000_0002);
		pulse(OP_AL, 4'h4, 4'h0);
		pulse(OP_EX, 4'h4, 4'h3);
		pulse(OP_RET, 4'h4, 4'h0);
		rchk("ex two tags", ARET_CNT_EX, 32'h0000_0003);
		wr(ARET_DOWN_SEL, 32'h0000_2000);
		pulse(OP_AL, 4'h4, 4'h0);
		pulse(OP_EX, 4'h4, 4'h1);
		pulse(OP_RET, 4'h4, 4'h1);
		rchk("ex cancel mask", ARET_CNT_EX, 32'h0000_0004);
		rchk("fe untouched", ARET_CNT_FE, 32'h0000_0000);
	endtask : t_exec

	// replay reissue and mispredict both land on the replay count only
	task t_replay;
		wr(ARET_RP_CTRL, 32'h0000_0005);
		pulse(OP_AL, 4'h5, 4'h0);
		pulse(OP_RP, 4'h5, 4'h0);
		#1;
		chk("reissue pulse", reissue_vld, 1'b1);
		chk("reissue slot", reissue_id, 4'h5);
		pulse(OP_RET, 4'h5, 4'h0);
		pulse(OP_AL, 4'h6, 4'h0);
		pulse(OP_MP, 4'h6, 4'h0);
		pulse(OP_RET, 4'h6, 4'h0);
		rchk("rp count", ARET_CNT_RP, 32'h0000_0002);
		rchk("ex untouched", ARET_CNT_EX, 32'h0000_0004);
	endtask : t_replay

	// decode-kind and trace-cache tags, trace-cache selector left at zero
	task t_front;
		wr(ARET_FE_CTRL, 32'h0000_0011); // kind 0 plus committed path
		pulse(OP_AL, 4'h8, 4'h0);
		pulse(OP_FE, 4'h8, 4'h1);
		pulse(OP_FE, 4'h8, 4'h1);
		pulse(OP_RET, 4'h8, 4'h0);
		pulse(OP_AL, 4'h9, 4'h0);
		pulse(OP_FE, 4'h9, 4'h0);
		pulse(OP_RET, 4'h9, 4'h0);
		pulse(OP_AL, 4'ha, 4'h0);
		pulse(OP_FE, 4'ha, 4'h2);
		pulse(OP_RET, 4'ha, 4'h0);
		rchk("fe count", ARET_CNT_FE, 32'h0000_0002);
		// with neither path bit set a tagged uop must not count
		wr(ARET_FE_CTRL, 32'h0000_0010);
		pulse(OP_AL, 4'h8, 4'h0);
		pulse(OP_FE, 4'h8, 4'h1);
		pulse(OP_RET, 4'h8, 4'h0);
		rchk("fe no path", ARET_CNT_FE, 32'h0000_0002);
		// cancelled-path select alone counts a bogus uop
		wr(ARET_FE_CTRL, 32'h0000_0012);
		pulse(OP_AL, 4'h8, 4'h0);
		pulse(OP_FE, 4'h8, 4'h1);
		pulse(OP_RET, 4'h8, 4'h1);
		rchk("fe cancel path", ARET_CNT_FE, 32'h0000_0003);
		rchk("rp untouched", ARET_CNT_RP, 32'h0000_0002);
	endtask : t_front

	// untagged instruction and uop retirement counts
	task t_untag;
		wr(ARET_UNTAG_CTRL, 32'h0000_0001);
		pulse(OP_AL, 4'hb, 4'h0);
		pulse(OP_AL, 4'hc, 4'h2);
		pulse(OP_AL, 4'hd, 4'h2);
		pulse(OP_RET, 4'hb, 4'h0);
		pulse(OP_RET, 4'hc, 4'h0);
		pulse(OP_RET, 4'hd, 4'h1);
		rchk("instr count", ARET_CNT_INSTR, 32'h0000_0001);
		rchk("uop count", ARET_CNT_UOP, 32'h0000_0002);
		// no precise sampling here; untagged counts off again, other mechanisms left as set
		wr(ARET_UNTAG_CTRL, 32'h0000_0000);
	endtask : t_untag

	// assist waits for the last in-flight uop before it goes
	task t_assist;
		logic seen;
		seen = 1'b0;
		pulse(OP_AL, 4'h7, 4'h0);
		pulse(OP_AS, 4'h0, 4'h0);
		#1;
		chk("stall on assist", alloc_stall, 1'b1);
		repeat (3) @(posedge clk);
		#1;
		chk("no go while busy", assist_go, 1'b0);
		pulse(OP_RET, 4'h7, 4'h0);
		for (int i = 0; i < 8 && !seen; i++) begin
			@(posedge clk);
			#1;
			seen = (assist_go === 1'b1);
		end
		chk("go after drain", seen, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk("stall released", alloc_stall, 1'b0);
	endtask : t_assist

	// main sequence: every input valued at time zero, reset held 20 cycles
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		{reg_wr, reg_rd, alloc_vld, alloc_notag, alloc_eoi, fe_evt_vld, fe_tc_evt} = 7'h00;
		{ex_evt_vld, rp_evt_vld, mp_evt_vld, ret_vld, ret_bogus, assist_req} = 6'h00;
		{reg_addr, reg_wdata} = 40'h00_0000_0000;
		{alloc_id, fe_evt_id, ex_evt_id, rp_evt_id, mp_evt_id, ret_id} = 24'h00_0000;
		{fe_evt_kind, ex_evt_kind} = 8'h00;
		n_errors = 0;
		n_compared = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_exec();
		t_replay();
		t_front();
		t_untag();
		t_assist();
		complete_run();
	end

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#20000;
		n_errors++;
		complete_run();
	end

endmodule : aret_top_tb_top

`default_nettype wire
